//--- include/crs_pkg.sv
// Package: constants and enums for the CPU register set
package crs_pkg;
  // ************************************************************
  // Condition flag layout
  // ************************************************************
  localparam int CRS_FLAG_CARRY = 0;
  localparam int CRS_FLAG_ZERO = 1;
  localparam int CRS_FLAG_NEG = 2;
  localparam int CRS_FLAG_IMASK = 3;
  localparam int CRS_FLAG_HALF = 4;
  localparam logic [7:0] CRS_FLAGS_ONES = 8'he0;
  localparam logic [7:0] CRS_FLAGS_RESET = 8'he8;
  // ************************************************************
  // Stack pointer
  // ************************************************************
  localparam logic [7:0] CRS_SP_HIGH = 8'h01;
  localparam logic [7:0] CRS_SP_LOW_RESET = 8'hff;
  localparam logic [15:0] CRS_SP_RESET = 16'h01ff;
  localparam logic [7:0] CRS_VAL_RESET = 8'h00;
  localparam logic [15:0] CRS_PC_RESET = 16'h0000;
  localparam logic [2:0] CRS_IRQ_FRAME = 3'h5;
  localparam logic [2:0] CRS_CALL_FRAME = 3'h2;
  // ************************************************************
  // Operations and selects
  // ************************************************************
  typedef enum logic [3:0] {
    CRS_ALU_NONE = 4'h0,
    CRS_ALU_ADD = 4'h1,
    CRS_ALU_ADC = 4'h2,
    CRS_ALU_SUB = 4'h3,
    CRS_ALU_LOGIC = 4'h4,
    CRS_ALU_SHIFT = 4'h5,
    CRS_ALU_BTEST = 4'h6
  } crs_alu_e;
  typedef enum logic [1:0] {
    CRS_DST_ACC = 2'h0,
    CRS_DST_X = 2'h1,
    CRS_DST_Y = 2'h2,
    CRS_DST_NONE = 2'h3
  } crs_dst_e;
  typedef enum logic [6:0] {
    CRS_ST_IDLE = 7'h01,
    CRS_ST_PUSH_PCL = 7'h02,
    CRS_ST_PUSH_PCH = 7'h04,
    CRS_ST_PUSH_X = 7'h08,
    CRS_ST_PUSH_A = 7'h10,
    CRS_ST_PUSH_CC = 7'h20,
    CRS_ST_POP = 7'h40
  } crs_state_e;
endpackage : crs_pkg

//--- verilog/crs_pending.sv
// Pending interrupt latches with mask gating
`timescale 1ns/10ps
module crs_pending (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [7:0] i_irq,
  input wire logic [7:0] i_ack,
  input wire logic i_mask,
  output logic [7:0] o_pending,
  output logic o_take
);
  import crs_pkg::*;
  // ************************************************************
  // Latches, set wins over acknowledge
  // ************************************************************
  logic [7:0] pend_reg;
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pend
      always_ff @(posedge i_clk) begin
        if (i_srst) begin
          pend_reg[g] <= 1'b0;
        end else if (i_irq[g]) begin
          pend_reg[g] <= 1'b1;
        end else if (i_ack[g]) begin
          pend_reg[g] <= 1'b0;
        end
      end
    end
  endgenerate
  assign o_pending = pend_reg;
  // No priority check against the running routine
  assign o_take = (|pend_reg) & ~i_mask;
endmodule : crs_pending

//--- verilog/crs_regset.sv
// CPU register set: accumulator, index, program counter, flags, stack
`timescale 1ns/10ps
module crs_regset (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire crs_pkg::crs_alu_e i_alu_op,
  input wire logic [7:0] i_opnd_a,
  input wire logic [7:0] i_opnd_b,
  input wire logic i_carry_in,
  input wire logic i_carry_out,
  input wire logic [7:0] i_logic_result,
  input wire crs_pkg::crs_dst_e i_dst,
  input wire logic i_load_we,
  input wire logic [7:0] i_load_data,
  input wire logic i_load_flags_nz,
  input wire logic i_flags_we,
  input wire logic [7:0] i_flags_data,
  input wire logic i_set_carry_op,
  input wire logic i_clear_carry_op,
  input wire logic i_set_interrupt_mask_op,
  input wire logic i_clear_interrupt_mask_op,
  input wire logic i_pc_we,
  input wire logic [15:0] i_pc_data,
  input wire logic i_sp_low_we,
  input wire logic [7:0] i_sp_low_data,
  input wire logic i_reset_stack_pointer_op,
  input wire logic i_push,
  input wire logic i_pop,
  input wire logic [7:0] i_irq,
  input wire logic [7:0] i_irq_ack,
  input wire logic i_irq_enter,
  input wire logic i_trap,
  input wire logic [15:0] i_vector,
  input wire logic i_return_from_interrupt,
  input wire logic [7:0] i_mem_rdata,
  output logic [7:0] o_acc,
  output logic [7:0] o_index_x,
  output logic [7:0] o_index_y,
  output logic [15:0] o_program_counter,
  output logic [7:0] o_condition_flags,
  output logic [15:0] o_stack_pointer,
  output logic [7:0] o_pending,
  output logic o_irq_take,
  output logic o_busy,
  output logic o_stack_we,
  output logic o_stack_re,
  output logic [15:0] o_stack_addr,
  output logic [7:0] o_stack_wdata
);
  import crs_pkg::*;
  // ************************************************************
  // State
  // ************************************************************
  logic [7:0] acc_reg, acc_next;
  logic [7:0] x_reg, x_next;
  logic [7:0] y_reg, y_next;
  logic [15:0] pc_reg, pc_next;
  logic [4:0] flags_reg, flags_next;
  logic [7:0] sp_reg, sp_next;
  crs_state_e state_reg, state_next;
  logic [2:0] pop_cnt_reg, pop_cnt_next;
  logic we_reg, we_next;
  logic re_reg, re_next;
  logic [15:0] addr_reg, addr_next;
  logic [7:0] wdata_reg, wdata_next;
  // ************************************************************
  // ALU flag terms
  // ************************************************************
  wire logic is_add = (i_alu_op == CRS_ALU_ADD) || (i_alu_op == CRS_ALU_ADC);
  wire logic cin = (i_alu_op == CRS_ALU_ADC) ? i_carry_in : 1'b0;
  wire logic [4:0] low_sum = {1'b0, i_opnd_a[3:0]} + {1'b0, i_opnd_b[3:0]} + {4'h0, cin};
  wire logic [8:0] full_sum = {1'b0, i_opnd_a} + {1'b0, i_opnd_b} + {8'h00, cin};
  wire logic [7:0] alu_result = is_add ? full_sum[7:0] : i_logic_result;
  wire logic alu_writes = (i_alu_op != CRS_ALU_NONE) && (i_alu_op != CRS_ALU_BTEST);
  wire logic alu_flags = alu_writes || i_load_flags_nz;
  wire logic [7:0] nz_value = i_load_flags_nz ? i_load_data : alu_result;
  wire logic carry_arith = is_add ? full_sum[8] : i_carry_out;
  wire logic irq_entry = (i_irq_enter | i_trap) && (state_reg == CRS_ST_IDLE);
  wire logic [7:0] sp_dec = sp_reg - 8'h01;
  wire logic [7:0] sp_inc = sp_reg + 8'h01;
  wire logic [15:0] sp_full = {CRS_SP_HIGH, sp_reg};
  wire logic [15:0] sp_inc_full = {CRS_SP_HIGH, sp_inc};
  wire logic [7:0] flags_full = CRS_FLAGS_ONES | {3'h0, flags_reg};
  // ************************************************************
  // Pending requests
  // ************************************************************
  crs_pending u_pending (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_irq(i_irq),
    .i_ack(i_irq_ack),
    .i_mask(flags_reg[CRS_FLAG_IMASK]),
    .o_pending(o_pending),
    .o_take(o_irq_take)
  );
  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    acc_next = acc_reg;
    x_next = x_reg;
    y_next = y_reg;
    pc_next = pc_reg;
    flags_next = flags_reg;
    sp_next = sp_reg;
    state_next = state_reg;
    pop_cnt_next = pop_cnt_reg;
    we_next = 1'b0;
    re_next = 1'b0;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    // Datapath writes only when no frame is in flight
    if (state_reg == CRS_ST_IDLE) begin
      if (alu_writes || i_load_we) begin
        case (i_dst)
          CRS_DST_ACC: begin
            acc_next = i_load_we ? i_load_data : alu_result;
          end
          CRS_DST_X: begin
            x_next = i_load_we ? i_load_data : alu_result;
          end
          CRS_DST_Y: begin
            y_next = i_load_we ? i_load_data : alu_result;
          end
          default: begin
          end
        endcase
      end
      if (i_flags_we) begin
        flags_next = i_flags_data[4:0];
      end
      if (is_add) begin
        flags_next[CRS_FLAG_HALF] = low_sum[4];
      end
      if (alu_flags) begin
        flags_next[CRS_FLAG_NEG] = nz_value[7];
        flags_next[CRS_FLAG_ZERO] = (nz_value == 8'h00);
      end
      if (i_alu_op != CRS_ALU_NONE && i_alu_op != CRS_ALU_LOGIC) begin
        flags_next[CRS_FLAG_CARRY] = carry_arith;
      end
      if (i_set_carry_op) begin
        flags_next[CRS_FLAG_CARRY] = 1'b1;
      end else if (i_clear_carry_op) begin
        flags_next[CRS_FLAG_CARRY] = 1'b0;
      end
      if (i_set_interrupt_mask_op) begin
        flags_next[CRS_FLAG_IMASK] = 1'b1;
      end else if (i_clear_interrupt_mask_op) begin
        flags_next[CRS_FLAG_IMASK] = 1'b0;
      end
      if (i_pc_we) begin
        pc_next = i_pc_data;
      end
      if (i_sp_low_we) begin
        sp_next = i_sp_low_data;
      end
      if (i_reset_stack_pointer_op) begin
        sp_next = CRS_SP_LOW_RESET;
      end
      // Single byte push and pop for calls and user stacking
      if (i_push) begin
        we_next = 1'b1;
        addr_next = sp_full;
        wdata_next = i_load_data;
        sp_next = sp_dec;
      end else if (i_pop) begin
        re_next = 1'b1;
        addr_next = sp_inc_full;
        sp_next = sp_inc;
      end
    end
    case (state_reg)
      CRS_ST_IDLE: begin
        if (irq_entry) begin
          // A pop in the same cycle is dropped, the frame owns the bus
          re_next = 1'b0;
          we_next = 1'b1;
          addr_next = sp_full;
          wdata_next = pc_reg[7:0];
          sp_next = sp_dec;
          state_next = CRS_ST_PUSH_PCL;
        end else if (i_return_from_interrupt) begin
          // A push in the same cycle would land on a popped slot
          we_next = 1'b0;
          re_next = 1'b1;
          addr_next = sp_inc_full;
          sp_next = sp_inc;
          pop_cnt_next = CRS_IRQ_FRAME;
          state_next = CRS_ST_POP;
        end
      end
      CRS_ST_PUSH_PCL: begin
        we_next = 1'b1;
        addr_next = sp_full;
        wdata_next = pc_reg[15:8];
        sp_next = sp_dec;
        state_next = CRS_ST_PUSH_PCH;
      end
      CRS_ST_PUSH_PCH: begin
        we_next = 1'b1;
        addr_next = sp_full;
        wdata_next = x_reg;
        sp_next = sp_dec;
        state_next = CRS_ST_PUSH_X;
      end
      CRS_ST_PUSH_X: begin
        we_next = 1'b1;
        addr_next = sp_full;
        wdata_next = acc_reg;
        sp_next = sp_dec;
        state_next = CRS_ST_PUSH_A;
      end
      CRS_ST_PUSH_A: begin
        // Y stays out of the frame
        we_next = 1'b1;
        addr_next = sp_full;
        wdata_next = flags_full;
        sp_next = sp_dec;
        state_next = CRS_ST_PUSH_CC;
      end
      CRS_ST_PUSH_CC: begin
        flags_next[CRS_FLAG_IMASK] = 1'b1;
        pc_next = i_vector;
        state_next = CRS_ST_IDLE;
      end
      CRS_ST_POP: begin
        // Data is taken in the same cycle as each registered read strobe
        case (pop_cnt_reg)
          3'h5: begin
            flags_next = i_mem_rdata[4:0];
            flags_next[CRS_FLAG_IMASK] = 1'b0;
          end
          3'h4: begin
            acc_next = i_mem_rdata;
          end
          3'h3: begin
            x_next = i_mem_rdata;
          end
          3'h2: begin
            pc_next[15:8] = i_mem_rdata;
          end
          default: begin
            pc_next[7:0] = i_mem_rdata;
          end
        endcase
        pop_cnt_next = pop_cnt_reg - 3'h1;
        if (pop_cnt_reg == 3'h1) begin
          state_next = CRS_ST_IDLE;
        end else begin
          re_next = 1'b1;
          addr_next = sp_inc_full;
          sp_next = sp_inc;
        end
      end
      default: begin
        state_next = CRS_ST_IDLE;
      end
    endcase
  end
  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      acc_reg <= CRS_VAL_RESET;
      x_reg <= CRS_VAL_RESET;
      y_reg <= CRS_VAL_RESET;
      pc_reg <= CRS_PC_RESET;
      flags_reg <= CRS_FLAGS_RESET[4:0];
      sp_reg <= CRS_SP_LOW_RESET;
      state_reg <= CRS_ST_IDLE;
      pop_cnt_reg <= 3'h0;
      we_reg <= 1'b0;
      re_reg <= 1'b0;
      addr_reg <= CRS_SP_RESET;
      wdata_reg <= CRS_VAL_RESET;
    end else begin
      acc_reg <= acc_next;
      x_reg <= x_next;
      y_reg <= y_next;
      pc_reg <= pc_next;
      flags_reg <= flags_next;
      sp_reg <= sp_next;
      state_reg <= state_next;
      pop_cnt_reg <= pop_cnt_next;
      we_reg <= we_next;
      re_reg <= re_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
    end
  end
  // ************************************************************
  // Outputs
  // ************************************************************
  assign o_acc = acc_reg;
  assign o_index_x = x_reg;
  assign o_index_y = y_reg;
  assign o_program_counter = pc_reg;
  assign o_condition_flags = flags_full;
  assign o_stack_pointer = sp_full;
  assign o_busy = (state_reg != CRS_ST_IDLE);
  assign o_stack_we = we_reg;
  assign o_stack_re = re_reg;
  assign o_stack_addr = addr_reg;
  assign o_stack_wdata = wdata_reg;
endmodule : crs_regset

//--- sim/crs_regset_props.sv
// Concurrent checks on the CPU register set ports
`timescale 1ns/10ps
module crs_regset_props (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_push,
  input wire logic i_pop,
  input wire logic i_sp_low_we,
  input wire logic i_reset_stack_pointer_op,
  input wire logic [7:0] i_irq,
  input wire logic i_irq_enter,
  input wire logic i_trap,
  input wire logic i_return_from_interrupt,
  input wire logic [7:0] o_condition_flags,
  input wire logic [15:0] o_stack_pointer,
  input wire logic [7:0] o_pending,
  input wire logic o_irq_take,
  input wire logic o_busy,
  input wire logic o_stack_we,
  input wire logic o_stack_re,
  input wire logic [15:0] o_stack_addr
);
  // ****
  // Qualifiers: only plain idle requests are judged
  // ****
  wire logic idle_ok = !o_busy && !i_irq_enter && !i_trap && !i_return_from_interrupt;
  wire logic sp_ok = idle_ok && !i_sp_low_we && !i_reset_stack_pointer_op;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  property p_ones; o_condition_flags[7:5] == 3'h7; endproperty
  a_ones: assert property (p_ones) else $error("flag top bits not ones");
  property p_sp_high; o_stack_pointer[15:8] == 8'h01; endproperty
  a_sp_high: assert property (p_sp_high) else $error("stack high byte moved");
  property p_push; sp_ok && i_push |=> o_stack_we && o_stack_addr == $past(o_stack_pointer)
    && o_stack_pointer[7:0] == $past(o_stack_pointer[7:0]) - 8'h01; endproperty
  a_push: assert property (p_push) else $error("push slot or step wrong");
  property p_pop; sp_ok && i_pop && !i_push |=> o_stack_re
    && o_stack_addr == {8'h01, $past(o_stack_pointer[7:0]) + 8'h01}
    && o_stack_pointer[7:0] == $past(o_stack_pointer[7:0]) + 8'h01; endproperty
  a_pop: assert property (p_pop) else $error("pop slot or step wrong");
  property p_entry; !o_busy && (i_irq_enter || i_trap) |=> o_stack_we
    && o_stack_addr == $past(o_stack_pointer) ##4 o_stack_we ##1 (o_condition_flags[3]
    && !o_busy && o_stack_pointer[7:0] == $past(o_stack_pointer[7:0], 6) - 8'h05); endproperty
  a_entry: assert property (p_entry) else $error("entry frame wrong");
  property p_ret; !o_busy && i_return_from_interrupt && !i_irq_enter && !i_trap |=> o_stack_re
    && o_stack_addr == {8'h01, $past(o_stack_pointer[7:0]) + 8'h01} ##4 o_stack_re
    ##2 (!o_busy && !o_condition_flags[3]); endproperty
  a_ret: assert property (p_ret) else $error("return frame wrong");
  property p_take; o_irq_take == (|o_pending && !o_condition_flags[3]); endproperty
  a_take: assert property (p_take) else $error("take not gated by mask");
  property p_latch; i_irq != 8'h00 |=> (o_pending & $past(i_irq)) == $past(i_irq); endproperty
  a_latch: assert property (p_latch) else $error("request not latched");
  property p_sp_top; idle_ok && i_reset_stack_pointer_op && !i_push && !i_pop
    |=> o_stack_pointer == 16'h01ff; endproperty
  a_sp_top: assert property (p_sp_top) else $error("stack reset op wrong");
  c_entry: cover property (i_irq_enter && !o_busy);
  c_ret: cover property (i_return_from_interrupt && !o_busy);
  c_wrap: cover property (i_push && o_stack_pointer[7:0] == 8'h00);
endmodule : crs_regset_props
bind crs_regset crs_regset_props chk_u (.*);

//--- sim/crs_regset_tb_top.sv
// Self-checking bench for the CPU register set
`timescale 1ns/10ps
module crs_regset_tb_top;
  import crs_pkg::*;
  typedef struct {int s; logic [15:0] v; logic [15:0] m;} crs_note_s;
  localparam int LDW = 0, LNZ = 1, FW = 2, SC = 3, PCW = 7, SPW = 8, SPR = 9;
  localparam int PSH = 10, POP = 11, ENT = 12, RET = 14;
  logic i_clk = 1'b0, i_srst = 1'b1, i_carry_in = 1'b0, i_carry_out = 1'b0;
  logic [14:0] st = '0;
  crs_alu_e i_alu_op = CRS_ALU_NONE;
  crs_dst_e i_dst = CRS_DST_NONE;
  logic [7:0] i_opnd_a = 8'h00, i_opnd_b = 8'h00, i_logic_result = 8'h00, i_load_data = 8'h00;
  logic [7:0] i_flags_data = 8'h00, i_sp_low_data = 8'h00, i_irq = 8'h00, i_irq_ack = 8'h00;
  logic [7:0] i_mem_rdata = 8'h00, o_acc, o_index_x, o_index_y, o_condition_flags, o_pending;
  logic [15:0] i_pc_data = 16'h0000, i_vector = 16'h0000, o_program_counter, o_stack_pointer;
  logic [15:0] o_stack_addr, m_pc, m_fm;
  logic [7:0] o_stack_wdata, m_f, m_sp, b, c, t;
  logic o_irq_take, o_busy, o_stack_we, o_stack_re;
  logic [7:0] m_r [3];
  logic [8:0] sum;
  logic [23:0] wq [$];
  logic [15:0] aq [$];
  logic [7:0] pq [$];
  crs_note_s rq [$];
  int n_fail = 0;
  int comparisons = 0;
  always #2 i_clk = ~i_clk;
  crs_regset dut_u (.i_clk(i_clk), .i_srst(i_srst), .i_alu_op(i_alu_op), .i_opnd_a(i_opnd_a),
    .i_opnd_b(i_opnd_b), .i_carry_in(i_carry_in), .i_carry_out(i_carry_out),
    .i_logic_result(i_logic_result), .i_dst(i_dst), .i_load_we(st[LDW]),
    .i_load_data(i_load_data), .i_load_flags_nz(st[LNZ]), .i_flags_we(st[FW]),
    .i_flags_data(i_flags_data), .i_set_carry_op(st[SC]), .i_clear_carry_op(st[SC+1]),
    .i_set_interrupt_mask_op(st[SC+2]), .i_clear_interrupt_mask_op(st[SC+3]),
    .i_pc_we(st[PCW]), .i_pc_data(i_pc_data), .i_sp_low_we(st[SPW]),
    .i_sp_low_data(i_sp_low_data), .i_reset_stack_pointer_op(st[SPR]), .i_push(st[PSH]),
    .i_pop(st[POP]), .i_irq(i_irq), .i_irq_ack(i_irq_ack), .i_irq_enter(st[ENT]),
    .i_trap(st[ENT+1]), .i_vector(i_vector), .i_return_from_interrupt(st[RET]),
    .i_mem_rdata(i_mem_rdata), .o_acc(o_acc), .o_index_x(o_index_x), .o_index_y(o_index_y),
    .o_program_counter(o_program_counter), .o_condition_flags(o_condition_flags),
    .o_stack_pointer(o_stack_pointer), .o_pending(o_pending), .o_irq_take(o_irq_take),
    .o_busy(o_busy), .o_stack_we(o_stack_we), .o_stack_re(o_stack_re),
    .o_stack_addr(o_stack_addr), .o_stack_wdata(o_stack_wdata));
  // ****
  // Shared tasks
  // ****
  task step;
    @(posedge i_clk);
    #1;
  endtask : step
  task chk(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk
  task note(input int s, input logic [15:0] v, input logic [15:0] m);
    rq.push_back('{s, v, m});
  endtask : note
  task note_all;
    note(0, m_r[0], 16'hffff);
    note(1, m_r[1], 16'hffff);
    note(2, m_r[2], 16'hffff);
    note(3, m_f, m_fm);
    note(4, {8'h01, m_sp}, 16'hffff);
    note(5, m_pc, 16'hffff);
  endtask : note_all
  // Idle edge after each pulse so no strobe is rewritten in one time step
  task fire(input int n);
    st[n] = 1'b1;
    step;
    st = '0;
    step;
  endtask : fire
  task settle;
    for (int k = 0; k < 12 && o_busy !== 1'b0; k++) step;
    step;
  endtask : settle
  task complete_run;
    if (n_fail == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  function automatic logic [15:0] cur(input int s);
    case (s)
      0: return o_acc;
      1: return o_index_x;
      2: return o_index_y;
      3: return o_condition_flags;
      4: return o_stack_pointer;
      5: return o_program_counter;
      6: return o_pending;
      default: return o_irq_take;
    endcase
  endfunction : cur
  // Read data stands in the strobe cycle; the design takes it at that cycle's closing edge
  always @(posedge i_clk) begin : mem
    #1;
    i_mem_rdata = (o_stack_re === 1'b1 && pq.size() > 0) ? pq.pop_front() : 8'($urandom);
  end
  always @(negedge i_clk) begin : mon
    crs_note_s e;
    if (o_stack_we === 1'b1) chk({o_stack_addr, o_stack_wdata}, wq.size() ? wq.pop_front() : 'x);
    if (o_stack_re === 1'b1) chk(o_stack_addr, aq.size() ? aq.pop_front() : 'x);
    while (rq.size() > 0) begin
      e = rq.pop_front();
      chk(cur(e.s) & e.m, e.v & e.m);
    end
  end
  initial begin
    #4000;
    n_fail++;
    complete_run;
  end
  initial begin
    void'($urandom(32'hb6406d13));
    repeat (8) @(posedge i_clk);
    #1;
    i_srst = 1'b0;
    m_r = '{default: 8'h00};
    {m_f, m_sp, m_pc, m_fm} = {8'he8, 8'hff, 16'h0000, 16'h00ff};
    note_all;
    // Last pass is an add, so half carry is known again
    for (int n = 0; n < 37; n++) begin
      i_alu_op = crs_alu_e'(4'(1 + n % 6));
      i_dst = i_alu_op == CRS_ALU_BTEST ? CRS_DST_NONE : crs_dst_e'(2'(n / 6 % 3));
      {i_opnd_a, i_opnd_b, i_logic_result, i_carry_in, i_carry_out} = 26'($urandom);
      if (n % 5 == 0) {i_opnd_a, i_opnd_b, i_logic_result} = 24'h9c6400;
      b = 8'(i_alu_op inside {CRS_ALU_ADD, CRS_ALU_ADC});
      c = 8'(i_alu_op == CRS_ALU_ADC && i_carry_in);
      sum = i_opnd_a + i_opnd_b + c;
      t = b[0] ? sum[7:0] : i_logic_result;
      if (i_alu_op == CRS_ALU_BTEST) m_f[0] = i_carry_out;
      else begin
        m_r[i_dst] = t;
        m_f[2:1] = {t[7], t == 8'h00};
        if (b[0]) {m_f[4], m_f[0]} = {(i_opnd_a[3:0] + i_opnd_b[3:0] + c[0]) > 5'h0f, sum[8]};
        else if (i_alu_op != CRS_ALU_LOGIC) m_f[0] = i_carry_out;
      end
      m_fm = b[0] ? 16'h00ff : 16'h00ef;
      step;
      note_all;
    end
    i_alu_op = CRS_ALU_NONE;
    i_flags_data = 8'($urandom);
    m_f = {3'b111, i_flags_data[4:0]};
    fire(FW);
    note_all;
    for (int k = 0; k < 4; k++) begin
      m_f[k < 2 ? 0 : 3] = ~k[0];
      fire(SC + k);
      note_all;
    end
    for (int k = 0; k < 3; k++) begin
      i_dst = crs_dst_e'(2'(k));
      i_load_data = k == 0 ? 8'h00 : 8'($urandom);
      m_r[k] = i_load_data;
      m_f[2:1] = {i_load_data[7], i_load_data == 8'h00};
      st[LNZ] = 1'b1;
      fire(LDW);
      note_all;
    end
    i_dst = CRS_DST_NONE;
    i_sp_low_data = 8'($urandom);
    st[SPW] = 1'b1;
    fire(SPR);
    note_all;
    i_sp_low_data = 8'h00;
    m_sp = 8'h00;
    fire(SPW);
    note_all;
    i_load_data = 8'($urandom);
    wq.push_back({16'h0100, i_load_data});
    m_sp = 8'hff;
    fire(PSH);
    note_all;
    aq.push_back(16'h0100);
    m_sp = 8'h00;
    fire(POP);
    note_all;
    b = 8'h01 << $urandom_range(7);
    i_irq = b;
    m_f[3] = 1'b1;
    fire(SC + 2);
    i_irq = 8'h00;
    note(6, b, 16'hffff);
    note(7, 16'h0000, 16'hffff);
    m_f[3] = 1'b0;
    fire(SC + 3);
    note(7, 16'h0001, 16'hffff);
    // The first frame starts at pointer 00, so its pushes wrap
    for (int k = 0; k < 2; k++) begin
      i_pc_data = 16'($urandom);
      m_pc = i_pc_data;
      fire(PCW);
      for (int j = 0; j < 5; j++) begin
        t = j == 0 ? m_pc[7:0] : j == 1 ? m_pc[15:8] : j == 2 ? m_r[1] : j == 3 ? m_r[0] : m_f;
        wq.push_back({8'h01, 8'(m_sp - j), t});
      end
      i_vector = 16'($urandom);
      {m_pc, m_sp, m_f[3]} = {i_vector, 8'(m_sp - 8'h05), 1'b1};
      fire(ENT + k);
      settle;
      note_all;
    end
    i_irq_ack = b;
    step;
    i_irq_ack = 8'h00;
    note(6, 16'h0000, 16'hffff);
    for (int j = 0; j < 5; j++) begin
      pq.push_back(8'($urandom));
      aq.push_back({8'h01, 8'(m_sp + j + 1)});
    end
    m_f = {3'b111, pq[0][4], 1'b0, pq[0][2:0]};
    {m_r[0], m_r[1], m_pc, m_sp} = {pq[1], pq[2], pq[3], pq[4], 8'(m_sp + 8'h05)};
    fire(RET);
    settle;
    note_all;
    step;
    complete_run;
  end
endmodule : crs_regset_tb_top
